// ==== wwd_cfg.svh ====
// offsets, field positions, reset values and timing figures of the windowed watchdog
`ifndef WWD_CFG_SVH
`define WWD_CFG_SVH

`define WWD_ADR_W          4
`define WWD_OFS_CTRL       4'h0
`define WWD_OFS_STATUS     4'h4
`define WWD_OFS_COUNT      4'h8

`define WWD_CTRL_PERIOD_LO 0
`define WWD_CTRL_WINDOW_LO 4
`define WWD_SEL_W          4
`define WWD_STAT_SYNC      0
`define WWD_STAT_CLRPEND   1
`define WWD_STAT_LOCK      7

`define WWD_CTRL_RST       8'h00
`define WWD_SEL_MAX        4'hB

`define WWD_OSC_HZ         1000
`define WWD_BASE_MS        8
`define WWD_BASE_TICKS     ((`WWD_BASE_MS * `WWD_OSC_HZ) / 1000)
`define WWD_CNT_W          14
`define WWD_SYNC_TICKS     2

`endif

// ==== wwd_pkg.sv ====
// types shared by the windowed watchdog modules
`include "wwd_cfg.svh"

package wwd_pkg;

  typedef enum logic [4:0] {
    WWD_OFF    = 5'h01,
    WWD_NORMAL = 5'h02,
    WWD_FIRST  = 5'h04,
    WWD_CLOSED = 5'h08,
    WWD_OPEN   = 5'h10
  } wwd_state_t;

  typedef struct packed {
    logic [`WWD_SEL_W-1:0] window;
    logic [`WWD_SEL_W-1:0] period;
  } wwd_ctrl_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic tick;
  } wwd_sync_t;

  typedef struct packed {
    wwd_ctrl_t             ctrl;
    wwd_ctrl_t             act;
    logic                  lock;
    logic                  boot;
    logic                  cfg_pend;
    logic [1:0]            cfg_cnt;
    logic                  clr_pend;
    logic [1:0]            clr_cnt;
    wwd_state_t            st;
    logic [`WWD_CNT_W-1:0] cnt;
    logic                  ack;
    logic [31:0]           dat;
    logic                  rst_req;
  } wwd_regs_t;

endpackage

// ==== wwd_osc_sync.sv ====
// three-stage sampler of the watchdog oscillator pin, one tick per rising edge
`timescale 1ns/1ps
`default_nettype none

module wwd_osc_sync (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic osc_i,
  output logic      tick_o
);
  import wwd_pkg::*;

  wwd_sync_t q;
  wwd_sync_t n;

  always_comb begin
    n      = q;
    n.s1   = osc_i;
    n.s2   = q.s1;
    n.s3   = q.s2;
    n.tick = 1'b0;
    // a level change counts only once the second and third stage agree
    if (q.s2 == q.s3) begin
      n.level = q.s3;
      n.tick  = q.s3 & ~q.level;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign tick_o = q.tick;

endmodule

`default_nettype wire

// ==== wwd_top.sv ====
// windowed watchdog with wishbone register access and a system reset request
//
// Summary of operation
// - missed clear before timeout requests system reset
// - eleven timeouts, eight ms to eight s
// - counter ticks from 1 kHz oscillator
// - counter runs; in normal mode each clear restarts period
// - mode chosen only by control register
// - window mode: early or late clear resets
// - closed period starts after first clear
// - counting continues in all sleep modes
// - lock bit blocks control changes
// - control writes synchronised before taking effect
// - nonzero period field enables the watchdog
// - nonzero window field enables window mode
// - lock set by one, cleared in debug
// - clear syncs 2 ticks, repeats ignored
`timescale 1ns/1ps
`default_nettype none

`include "wwd_cfg.svh"

module wwd_top (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [`WWD_ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  input  wire logic                   osc_clk_i,
  input  wire logic                   watchdog_clear_instruction_i,
  input  wire logic                   dbg_halt_i,
  input  wire logic                   ccp_ok_i,
  input  wire wwd_pkg::wwd_ctrl_t     fuse_ctrl_i,
  output logic                        sys_rst_req_o
);
  import wwd_pkg::*;

  wwd_regs_t q;
  wwd_regs_t n;
  logic      tick;
  logic      req;
  logic      wr;
  logic      apply;
  logic      clear_ev;
  logic      timeout;
  logic [`WWD_CNT_W-1:0] lim;

  // the 1 kHz oscillator is sampled, not used as a clock: one domain only
  wwd_osc_sync u_osc_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .osc_i  (osc_clk_i),
    .tick_o (tick)
  );

  // ticks for a selection code; reserved codes above the top entry use it
  function automatic logic [`WWD_CNT_W-1:0] sel_ticks(input logic [`WWD_SEL_W-1:0] sel);
    logic [`WWD_SEL_W-1:0] s;
    s = (sel > `WWD_SEL_MAX) ? `WWD_SEL_MAX : sel;
    if (s == 4'h0) begin
      sel_ticks = '0;
    end else begin
      sel_ticks = `WWD_CNT_W'(`WWD_BASE_TICKS) << (s - 4'h1);
    end
  endfunction

  // state a freshly armed watchdog starts in
  function automatic wwd_state_t start_state(input wwd_ctrl_t c);
    if (c.period == 4'h0) begin
      start_state = WWD_OFF;
    end else if (c.window != 4'h0) begin
      start_state = WWD_FIRST;
    end else begin
      start_state = WWD_NORMAL;
    end
  endfunction

  always_comb begin
    n          = q;
    n.ack      = 1'b0;
    n.rst_req  = 1'b0;
    apply      = 1'b0;
    clear_ev   = 1'b0;
    timeout    = 1'b0;
    lim        = '0;
    req        = wb_cyc_i & wb_stb_i;
    // a write lands at the edge where the master sees ack
    wr         = req & q.ack & wb_we_i & wb_sel_i[0];

    // bus answer: one wait cycle, data registered with the ack
    if (req & ~q.ack) begin
      n.ack = 1'b1;
      n.dat = '0;
      case (wb_adr_i)
        `WWD_OFS_CTRL: begin
          n.dat[7:0] = q.ctrl;
        end
        `WWD_OFS_STATUS: begin
          n.dat[`WWD_STAT_LOCK]    = q.lock;
          n.dat[`WWD_STAT_SYNC]    = q.cfg_pend;
          n.dat[`WWD_STAT_CLRPEND] = q.clr_pend;
        end
        `WWD_OFS_COUNT: begin
          n.dat[`WWD_CNT_W-1:0] = q.cnt;
          n.dat[20:16]          = q.st;
        end
        default: begin
          n.dat = '0;
        end
      endcase
    end

    // synchronisation stages advance on oscillator ticks only
    if (tick && q.cfg_pend) begin
      if (q.cfg_cnt == 2'(`WWD_SYNC_TICKS - 1)) begin
        n.act      = q.ctrl;
        n.cfg_pend = 1'b0;
        apply      = 1'b1;
      end else begin
        n.cfg_cnt = q.cfg_cnt + 2'h1;
      end
    end
    if (tick && q.clr_pend) begin
      if (q.clr_cnt == 2'(`WWD_SYNC_TICKS - 1)) begin
        n.clr_pend = 1'b0;
        clear_ev   = 1'b1;
      end else begin
        n.clr_cnt = q.clr_cnt + 2'h1;
      end
    end

    // fuse value is caught one cycle after reset release
    if (q.boot) begin
      n.boot     = 1'b0;
      n.ctrl     = fuse_ctrl_i;
      n.lock     = |fuse_ctrl_i;
      n.cfg_pend = 1'b1;
      n.cfg_cnt  = 2'h0;
    end

    // control writes need the protection key, no lock and an idle sync stage
    if (wr && wb_adr_i == `WWD_OFS_CTRL && ccp_ok_i && !q.lock && !q.cfg_pend) begin
      n.ctrl     = wwd_ctrl_t'(wb_dat_i[7:0]);
      n.cfg_pend = 1'b1;
      n.cfg_cnt  = 2'h0;
    end
    if (wr && wb_adr_i == `WWD_OFS_STATUS && ccp_ok_i) begin
      if (wb_dat_i[`WWD_STAT_LOCK]) begin
        n.lock = 1'b1;
      end else if (dbg_halt_i) begin
        n.lock = 1'b0;
      end
    end

    // a clear issued while one is in flight is dropped
    if (watchdog_clear_instruction_i && !q.clr_pend && q.st != WWD_OFF) begin
      n.clr_pend = 1'b1;
      n.clr_cnt  = 2'h0;
    end

    // no sleep input gates the tick, so counting never pauses in sleep
    if (dbg_halt_i) begin
      n.cnt = '0;
      n.st  = start_state(q.act);
    end else if (apply) begin
      n.cnt = '0;
      n.st  = start_state(n.act);
    end else if (tick) begin
      if (q.st == WWD_CLOSED) begin
        lim = sel_ticks(q.act.window);
      end else begin
        lim = sel_ticks(q.act.period);
      end
      case (q.st)
        WWD_OFF: begin
          n.cnt = '0;
        end
        WWD_NORMAL: begin
          if (clear_ev) begin
            n.cnt = '0;
          end else if (q.cnt == lim - 1'b1) begin
            timeout = 1'b1;
          end else begin
            n.cnt = q.cnt + 1'b1;
          end
        end
        WWD_FIRST: begin
          if (clear_ev) begin
            n.cnt = '0;
            n.st  = WWD_CLOSED;
          end else if (q.cnt == lim - 1'b1) begin
            timeout = 1'b1;
          end else begin
            n.cnt = q.cnt + 1'b1;
          end
        end
        WWD_CLOSED: begin
          if (clear_ev) begin
            timeout = 1'b1;
          end else if (q.cnt == lim - 1'b1) begin
            n.cnt = '0;
            n.st  = WWD_OPEN;
          end else begin
            n.cnt = q.cnt + 1'b1;
          end
        end
        WWD_OPEN: begin
          if (clear_ev) begin
            n.cnt = '0;
            n.st  = WWD_CLOSED;
          end else if (q.cnt == lim - 1'b1) begin
            timeout = 1'b1;
          end else begin
            n.cnt = q.cnt + 1'b1;
          end
        end
        default: begin
          n.cnt = '0;
          n.st  = WWD_OFF;
        end
      endcase
      // the reset controller normally resets us; rearm in case it does not
      if (timeout) begin
        n.rst_req = 1'b1;
        n.cnt     = '0;
        n.st      = start_state(q.act);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q      <= '0;
      q.boot <= 1'b1;
      q.st   <= WWD_OFF;
    end else begin
      q <= n;
    end
  end

  assign wb_dat_o      = q.dat;
  assign wb_ack_o      = q.ack;
  assign sys_rst_req_o = q.rst_req;

endmodule

`default_nettype wire

// ==== wwd_props.sv ====
// concurrent checks on the windowed watchdog ports
`timescale 1ns/1ps
`default_nettype none
module wwd_props (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        osc_clk_i,
  input wire logic        sys_rst_req_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd;
    s_req ##0 !wb_we_i;
  endsequence
  logic       osc_q;
  logic [4:0] quiet_r;
  // saturates so a stopped oscillator stays visible
  always_ff @(posedge clk_i) begin
    osc_q <= osc_clk_i;
    if (rst_i || osc_q != osc_clk_i) quiet_r <= 5'h00;
    else if (quiet_r != 5'h1F) quiet_r <= quiet_r + 5'h01;
  end
  a_ack_next: assert property (s_req |=> wb_ack_o) else $error("ack late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack unasked");
  a_rst_pulse: assert property (sys_rst_req_o |=> !sys_rst_req_o)
    else $error("reset pulse long");
  a_rst_osc: assert property (sys_rst_req_o |-> quiet_r < 5'h0C)
    else $error("reset without tick");
  a_unmapped_zero: assert property (s_rd ##0 (wb_adr_i != 4'h0 && wb_adr_i != 4'h4
    && wb_adr_i != 4'h8) |=> wb_dat_o == 32'h0) else $error("unmapped read");
  a_state_hot: assert property (s_rd ##0 wb_adr_i == 4'h8 |=> $onehot(wb_dat_o[20:16]))
    else $error("state not one-hot");
  a_quiet_release: assert property ($fell(rst_i) |-> !wb_ack_o && !sys_rst_req_o)
    else $error("output after reset");
endmodule
bind wwd_top wwd_props wwd_props_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .osc_clk_i(osc_clk_i), .sys_rst_req_o(sys_rst_req_o));
`default_nettype wire

// ==== wwd_core_model.sv ====
// stand-in for the core and oscillator: free-running watchdog clock and clear pulses
`timescale 1ns/1ps
`default_nettype none
module wwd_core_model (
  input  wire logic clk_i,
  input  wire logic clr_go_i,
  output logic      osc_o,
  output logic      clr_o
);
  logic [2:0] ph_r;
  initial begin
    ph_r = 3'h0;
    osc_o = 1'b0;
    clr_o = 1'b0;
  end
  // the oscillator never stops; ten system cycles a period keeps runs short
  always @(posedge clk_i) begin
    ph_r <= (ph_r == 3'h4) ? 3'h0 : ph_r + 3'h1;
    if (ph_r == 3'h4) osc_o <= ~osc_o;
    clr_o <= clr_go_i;
  end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the windowed watchdog
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_i, rst_i, cyc, stb, we, dbg, ccp, go, osc, clr, rq, ack;
  logic [3:0]  adr, p;
  logic [31:0] di, dq, q;
  logic [7:0]  fuse;
  int          err_total, checks_done, t;
  wwd_top wwd_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(di), .wb_dat_o(dq),
    .wb_ack_o(ack), .osc_clk_i(osc), .watchdog_clear_instruction_i(clr), .dbg_halt_i(dbg),
    .ccp_ok_i(ccp), .fuse_ctrl_i(wwd_pkg::wwd_ctrl_t'(fuse)), .sys_rst_req_o(rq));
  wwd_core_model wwd_core_model_i (.clk_i(clk_i), .clr_go_i(go), .osc_o(osc), .clr_o(clr));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    di <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = dq;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) begin
      err_total++;
      close_out();
    end
  endtask
  // control writes only land after the crossing, so poll the busy flag
  task automatic sync;
    int n;
    n = 0;
    do begin
      bus(1'b0, 4'h4, 8'h00);
      n++;
    end while (q[0] !== 1'b0 && n < 40);
    if (n >= 40) begin
      err_total++;
      close_out();
    end
  endtask
  // ticks seen until a reset pulse, or -1 if none within c cycles
  task automatic watch(input int c, output int k);
    logic po;
    k = 0;
    po = osc;
    for (int i = 0; i < c; i++) begin
      @(posedge clk_i);
      if (rq === 1'b1) return;
      k += int'(osc && !po);
      po = osc;
    end
    k = -1;
  endtask
  task automatic clear;
    @(posedge clk_i);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
  endtask
  initial begin
    {rst_i, ccp} = 2'h3;
    {cyc, stb, we, dbg, go} = 5'h00;
    adr = 4'h0;
    fuse = 8'h00;
    di = 32'h0;
    err_total = 0;
    checks_done = 0;
    void'($urandom(25));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    sync();
    bus(1'b0, 4'h0, 8'h00);
    cmp(q, 32'h0);
    bus(1'b0, 4'h8, 8'h00);
    cmp(q[20:16], 5'h01);
    bus(1'b1, 4'hC, 8'($urandom));
    bus(1'b0, 4'hC, 8'h00);
    cmp(q, 32'h0);
    $display("test reset done");
    repeat (3) begin
      p = 4'($urandom_range(3, 1));
      bus(1'b1, 4'h0, {4'h0, p});
      sync();
      watch(2000, t);
      cmp(t >= (8 << (p - 1)) - 1 && t <= (8 << (p - 1)) + 1, 1);
    end
    bus(1'b1, 4'h0, 8'h02);
    sync();
    repeat (4) begin
      clear();
      bus(1'b0, 4'h4, 8'h00);
      cmp(q[1], 1'b1);
      watch(100, t);
      cmp(t, -1);
    end
    $display("test normal done");
    bus(1'b1, 4'h0, 8'h11);
    sync();
    clear();
    watch(100, t);
    cmp(t, -1);
    clear();
    // the clear lands up to two ticks later, so look past that point
    watch(40, t);
    cmp(t, -1);
    clear();
    watch(100, t);
    cmp(t >= 0 && t <= 4, 1);
    $display("test window done");
    bus(1'b1, 4'h0, 8'h00);
    sync();
    ccp <= 1'b0;
    bus(1'b1, 4'h0, 8'h03);
    bus(1'b0, 4'h0, 8'h00);
    cmp(q, 32'h0);
    bus(1'b1, 4'h4, 8'h80);
    bus(1'b0, 4'h4, 8'h00);
    cmp(q[7], 1'b0);
    ccp <= 1'b1;
    bus(1'b1, 4'h4, 8'h80);
    bus(1'b0, 4'h4, 8'h00);
    cmp(q[7], 1'b1);
    bus(1'b1, 4'h0, 8'h05);
    bus(1'b0, 4'h0, 8'h00);
    cmp(q, 32'h0);
    bus(1'b1, 4'h4, 8'h00);
    bus(1'b0, 4'h4, 8'h00);
    cmp(q[7], 1'b1);
    dbg <= 1'b1;
    bus(1'b1, 4'h4, 8'h00);
    bus(1'b0, 4'h4, 8'h00);
    cmp(q[7], 1'b0);
    dbg <= 1'b0;
    $display("test protect done");
    // second reset in mid-run: a nonzero fuse locks the watchdog at boot, and a nonzero fuse period field also arms it
    fuse <= 8'h01;
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, 4'h4, 8'h00);
    cmp(q[7], 1'b1);
    sync();
    bus(1'b1, 4'h0, 8'h00);
    bus(1'b0, 4'h0, 8'h00);
    cmp(q, 32'h1);
    // one oscillator period has gone by before the watch starts
    watch(200, t);
    cmp(t >= 6 && t <= 8, 1);
    $display("test fuse done");
    close_out();
  end
endmodule
`default_nettype wire
